// ### core/acs_regs.vh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * converter sequencer. Assumes an APB slave with 32-bit data, one word each.
 */
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

`define ACS_OFF_CTRL0 12'h000
`define ACS_OFF_CTRL1 12'h004
`define ACS_OFF_CTRL2 12'h008
`define ACS_OFF_RESH 12'h00C
`define ACS_OFF_RESL 12'h010
`define ACS_OFF_FLAG 12'h014
`define ACS_OFF_INTEN 12'h018
`define ACS_OFF_STATUS 12'h01C

`define ACS_CTRL0_ENABLE 0
`define ACS_CTRL0_GO 1
`define ACS_CTRL0_CHS_LO 2
`define ACS_CTRL0_CHS_HI 6
`define ACS_CTRL1_PREF_LO 0
`define ACS_CTRL1_PREF_HI 1
`define ACS_CTRL1_CS_LO 4
`define ACS_CTRL1_CS_HI 6
`define ACS_CTRL1_FMT 7
`define ACS_CTRL2_TRIG_LO 4
`define ACS_CTRL2_TRIG_HI 7

`define ACS_RST_CTRL0 8'h00
`define ACS_RST_CTRL1 8'h00
`define ACS_RST_CTRL2 8'h00

`define ACS_CHS_TEMP 5'h1D
`define ACS_CHS_FVR 5'h1F
`define ACS_CHS_LAST_PIN 5'h0B
`define ACS_PREF_VDD 2'h0
`define ACS_PREF_EXT 2'h2
`define ACS_TRIG_NONE 4'h0
`define ACS_TRIG_T0 4'h3
`define ACS_TRIG_T1 4'h4
`define ACS_TRIG_T2 4'h5
`define ACS_TRIG_LC1 4'h8
`define ACS_TRIG_LC2 4'h9

// A conversion is 11.5 bit periods, counted in half periods.
`define ACS_CONV_HALF_PERIODS 5'h17
`define ACS_RESULT_BITS 10

`endif

// ### core/acs_sync2.v
/*
 * Two-flop synchroniser for one level from outside the clock domain.
 * Assumes clk and asynchronous active-low resetn.
 */
module acs_sync2 (
  input wire clk,
  input wire resetn,
  input wire d,
  output wire q
);

  reg meta_q;
  reg sync_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule // acs_sync2

// ### core/acs_tick_gen.v
/*
 * Half-bit-period tick generator for the conversion clock. Divides clk by the
 * selected ratio, or passes synchronised edges of the internal RC clock.
 * Assumes rc_sync is already synchronised to clk.
 */
`include "acs_regs.vh"

module acs_tick_gen (
  input wire clk,
  input wire resetn,
  input wire run,
  input wire [2:0] clock_sel,
  input wire rc_sync,
  output reg tick
);

  reg [5:0] div_q;
  reg rc_prev_q;
  reg [5:0] half_div;

  // Code bit 2 picks the intermediate ratio; bits 1:0 step by four.
  // Divider ratio decode.
  always @* begin
    case (clock_sel)
      3'h0: half_div = 6'h00;
      3'h4: half_div = 6'h01;
      3'h1: half_div = 6'h03;
      3'h5: half_div = 6'h07;
      3'h2: half_div = 6'h0F;
      3'h6: half_div = 6'h1F;
      default: half_div = 6'h00;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 6'h00;
      rc_prev_q <= 1'b0;
      tick <= 1'b0;
    end else begin
      rc_prev_q <= rc_sync;
      if (!run) begin
        div_q <= 6'h00;
        tick <= 1'b0;
      end else if (clock_sel[1:0] == 2'b11) begin
        // Each RC edge is half a bit period.
        tick <= rc_sync ^ rc_prev_q;
      end else if (div_q >= half_div) begin
        div_q <= 6'h00;
        tick <= 1'b1;
      end else begin
        div_q <= div_q + 6'h01;
        tick <= 1'b0;
      end
    end
  end

endmodule // acs_tick_gen

// ### core/acs_sequencer.v
/*
 * Conversion sequencer of a 10-bit successive-approximation converter with
 * an APB register file, auto-trigger, result formatting and Sleep handling.
 * Assumes the analog comparator answers on cmp_in within one half bit period,
 * and that trigger, sleep, RC clock and comparator come from other domains.
 */
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`include "acs_regs.vh"

module acs_sequencer (
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire cmp_in,
  input wire rc_clock_in,
  input wire sleep_in,
  input wire timer0_wrap_event,
  input wire timer1_wrap_event,
  input wire timer2_period_event,
  input wire logic_cell1_output,
  input wire logic_cell2_output,
  output reg [4:0] mux_select_q,
  output reg [13:0] mux_onehot_q,
  output reg pos_ref_ext_q,
  output reg [9:0] dac_code_q,
  output reg sample_q,
  output reg analog_power_q,
  output reg conv_done_flag_q,
  output reg wakeup_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for everything arriving from other domains.
  wire [7:0] async_in;
  wire [7:0] sync_in;
  assign async_in = {cmp_in, rc_clock_in, sleep_in, timer0_wrap_event,
    timer1_wrap_event, timer2_period_event, logic_cell1_output, logic_cell2_output};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
      acs_sync2 u_sync (
        .clk(clk),
        .resetn(resetn),
        .d(async_in[gi]),
        .q(sync_in[gi])
      );
    end
  endgenerate

  // The comparator round trip is three clocks (trial register, two sync flops).
  // The divide-by-2 clock therefore cannot give valid decisions; it keeps its timing only.
  wire cmp_s = sync_in[7];
  wire rc_s = sync_in[6];
  wire sleep_s = sync_in[5];

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  reg module_enable_q;
  reg go_q;
  reg [4:0] channel_select_q;
  reg result_format_q;
  reg [2:0] conv_clock_select_q;
  reg [1:0] pos_ref_select_q;
  reg [3:0] auto_trigger_select_q;
  reg [7:0] result_high_reg_q;
  reg [7:0] result_low_reg_q;
  reg conv_done_int_enable_q;
  reg busy_q;
  reg [4:0] half_q;
  reg [3:0] bit_q;
  reg [9:0] sar_q;
  reg last_bit_q;
  reg trig_prev_q;
  reg slept_off_q;

  wire apb_wr = psel && penable && pwrite;
  wire apb_rd = psel && penable && !pwrite;
  wire hit_ctrl0 = apb_wr && (paddr == `ACS_OFF_CTRL0);
  wire hit_flag = apb_wr && (paddr == `ACS_OFF_FLAG);
  wire rc_sel = (conv_clock_select_q[1:0] == 2'b11);

  reg trig_sel;
  always @* begin
    case (auto_trigger_select_q)
      `ACS_TRIG_T0: trig_sel = sync_in[4];
      `ACS_TRIG_T1: trig_sel = sync_in[3];
      `ACS_TRIG_T2: trig_sel = sync_in[2];
      `ACS_TRIG_LC1: trig_sel = sync_in[1];
      `ACS_TRIG_LC2: trig_sel = sync_in[0];
      default: trig_sel = 1'b0;
    endcase
  end
  wire trig_rise = trig_sel && !trig_prev_q && module_enable_q;

  wire tick;
  acs_tick_gen u_tick (
    .clk(clk),
    .resetn(resetn),
    .run(busy_q),
    .clock_sel(conv_clock_select_q),
    .rc_sync(rc_s),
    .tick(tick)
  );

  // Start needs the enable already set; a write setting both does not start.
  // Start qualification.
  wire sw_go = hit_ctrl0 && pwdata[`ACS_CTRL0_GO] && module_enable_q && !busy_q;
  wire sw_stop = hit_ctrl0 && !pwdata[`ACS_CTRL0_GO] && busy_q;
  wire start = !busy_q && (sw_go || trig_rise) && !(sleep_s && !rc_sel);
  // Last half period ends the conversion.
  wire finish = busy_q && tick && (half_q == `ACS_CONV_HALF_PERIODS - 5'h01);
  // Divider clock does not survive Sleep.
  wire sleep_abort = busy_q && sleep_s && !rc_sel;
  wire disable_stop = busy_q && hit_ctrl0 && !pwdata[`ACS_CTRL0_ENABLE];

  // Unresolved bits copy the last resolved bit.
  reg [9:0] partial;
  integer k;
  always @* begin
    partial = sar_q;
    for (k = 0; k < 10; k = k + 1) begin
      if (k < 10 - bit_q) begin
        partial[k] = last_bit_q;
      end
    end
  end
  // Every bit is resolved before the last half period, so completion loads sar_q as is.
  wire [9:0] final_val = finish ? sar_q : partial;
  wire load = finish || sw_stop;

  ////////////////////////////////////////////////////////////////////////////
  // All state returns to reset values.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      module_enable_q <= 1'b0;
      go_q <= 1'b0;
      channel_select_q <= 5'h00;
      result_format_q <= 1'b0;
      conv_clock_select_q <= 3'h0;
      pos_ref_select_q <= 2'h0;
      auto_trigger_select_q <= 4'h0;
      result_high_reg_q <= 8'h00;
      result_low_reg_q <= 8'h00;
      conv_done_int_enable_q <= 1'b0;
      conv_done_flag_q <= 1'b0;
      busy_q <= 1'b0;
      half_q <= 5'h00;
      bit_q <= 4'h0;
      sar_q <= 10'h000;
      last_bit_q <= 1'b0;
      trig_prev_q <= 1'b0;
      slept_off_q <= 1'b0;
      wakeup_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_sel;
      if (apb_wr) begin
        case (paddr)
          `ACS_OFF_CTRL0: begin
            module_enable_q <= pwdata[`ACS_CTRL0_ENABLE];
            channel_select_q <= pwdata[`ACS_CTRL0_CHS_HI:`ACS_CTRL0_CHS_LO];
          end
          `ACS_OFF_CTRL1: begin
            result_format_q <= pwdata[`ACS_CTRL1_FMT];
            conv_clock_select_q <= pwdata[`ACS_CTRL1_CS_HI:`ACS_CTRL1_CS_LO];
            pos_ref_select_q <= pwdata[`ACS_CTRL1_PREF_HI:`ACS_CTRL1_PREF_LO];
          end
          `ACS_OFF_CTRL2: auto_trigger_select_q <= pwdata[`ACS_CTRL2_TRIG_HI:`ACS_CTRL2_TRIG_LO];
          `ACS_OFF_RESH: result_high_reg_q <= pwdata[7:0];
          `ACS_OFF_RESL: result_low_reg_q <= pwdata[7:0];
          `ACS_OFF_INTEN: conv_done_int_enable_q <= pwdata[0];
          default: ;
        endcase
      end
      // Set wins over a software clear.
      if (finish) begin
        conv_done_flag_q <= 1'b1;
      end else if (hit_flag && pwdata[0]) begin
        conv_done_flag_q <= 1'b0;
      end
      if (start) begin
        busy_q <= 1'b1;
        go_q <= 1'b1;
        half_q <= 5'h00;
        bit_q <= 4'h0;
        sar_q <= 10'h200;
        last_bit_q <= 1'b0;
        slept_off_q <= 1'b0;
      end else if (load || sleep_abort || disable_stop) begin
        busy_q <= 1'b0;
        go_q <= 1'b0;
        // Sleep power-down with the enable left set.
        slept_off_q <= sleep_s && !(finish && conv_done_int_enable_q);
      end else if (busy_q && tick) begin
        half_q <= half_q + 5'h01;
        // Odd half periods after the first resolve one bit each.
        if (half_q[0] && half_q != 5'h01 && bit_q < 4'hA) begin
          sar_q[4'h9 - bit_q] <= cmp_s;
          last_bit_q <= cmp_s;
          if (bit_q < 4'h9) begin
            sar_q[4'h8 - bit_q] <= 1'b1;
          end
          bit_q <= bit_q + 4'h1;
        end
      end
      if (!sleep_s) begin
        slept_off_q <= 1'b0;
      end
      if (load) begin
        if (result_format_q) begin
          result_high_reg_q <= {6'h00, final_val[9:8]};
          result_low_reg_q <= final_val[7:0];
        end else begin
          result_high_reg_q <= final_val[9:2];
          result_low_reg_q <= {final_val[1:0], 6'h00};
        end
      end
      // Wake-up on enabled completion in Sleep.
      wakeup_q <= sleep_s && conv_done_int_enable_q && (finish || (wakeup_q && conv_done_flag_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog-side controls.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mux_select_q <= 5'h00;
      mux_onehot_q <= 14'h0000;
      pos_ref_ext_q <= 1'b0;
      dac_code_q <= 10'h000;
      sample_q <= 1'b0;
      analog_power_q <= 1'b0;
    end else begin
      mux_select_q <= channel_select_q;
      if (channel_select_q <= `ACS_CHS_LAST_PIN) begin
        mux_onehot_q <= 14'h0001 << channel_select_q;
      end else if (channel_select_q == `ACS_CHS_TEMP) begin
        mux_onehot_q <= 14'h1000;
      end else if (channel_select_q == `ACS_CHS_FVR) begin
        mux_onehot_q <= 14'h2000;
      end else begin
        mux_onehot_q <= 14'h0000;
      end
      // Reference pin only for code 10.
      pos_ref_ext_q <= (pos_ref_select_q == `ACS_PREF_EXT);
      dac_code_q <= sar_q;
      sample_q <= module_enable_q && !busy_q && !slept_off_q;
      analog_power_q <= module_enable_q && !slept_off_q && !(sleep_s && !rc_sel);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read path; zero wait states.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          `ACS_OFF_CTRL0: prdata <= {25'h0, channel_select_q, go_q, module_enable_q};
          `ACS_OFF_CTRL1: prdata <= {24'h0, result_format_q, conv_clock_select_q,
            2'b00, pos_ref_select_q};
          `ACS_OFF_CTRL2: prdata <= {24'h0, auto_trigger_select_q, 4'h0};
          `ACS_OFF_RESH: prdata <= {24'h0, result_high_reg_q};
          `ACS_OFF_RESL: prdata <= {24'h0, result_low_reg_q};
          `ACS_OFF_FLAG: prdata <= {31'h0, conv_done_flag_q};
          `ACS_OFF_INTEN: prdata <= {31'h0, conv_done_int_enable_q};
          `ACS_OFF_STATUS: prdata <= {26'h0, bit_q, slept_off_q, busy_q};
          default: begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  wire unused_rd = apb_rd;

endmodule // acs_sequencer

// ### verification/acs_analog_model.sv
/*
 * Comparator and internal RC oscillator seen by the converter sequencer.
 * Assumes the trial code and the analog level share one 10-bit scale.
 */
module acs_analog_model (
  input logic [9:0] dac_code_q,
  input logic [9:0] vin,
  output logic cmp_in,
  output logic rc_clock_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // The level sits half a step above vin, so a trial code never ties with it.
  assign cmp_in = {vin, 1'b1} > {dac_code_q, 1'b0};
  // The oscillator runs free, as it does in the device; each edge is half a period.
  initial rc_clock_in = 1'b0;
  always #100 rc_clock_in = ~rc_clock_in;
endmodule // acs_analog_model

// ### verification/acs_seq_asserts.sv
/*
 * Port checker of the converter sequencer.
 * Assumes it is bound to acs_sequencer and sees only that module's ports.
 */
`include "acs_regs.vh"
module acs_seq_chk (
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire sleep_in,
  input wire [4:0] mux_select_q,
  input wire [13:0] mux_onehot_q,
  input wire pos_ref_ext_q,
  input wire analog_power_q,
  input wire conv_done_flag_q,
  input wire wakeup_q
);
  timeunit 1ns;
  timeprecision 100ps;
  wire wr_ok = psel && penable && pwrite && pready;
  reg [2:0] cs_q;
  reg ie_q;
  // Shadows of the clock field and interrupt enable, taken from accepted writes.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_q <= 3'h0;
      ie_q <= 1'b0;
    end else if (wr_ok) begin
      if (paddr == `ACS_OFF_CTRL1) cs_q <= pwdata[6:4];
      if (paddr == `ACS_OFF_INTEN) ie_q <= pwdata[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ready_one_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  unmapped_err_a: assert property (psel && !penable && paddr > `ACS_OFF_STATUS
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chan_onehot_a: assert property ($onehot0(mux_onehot_q))
    else $error("more than one channel connected");
  pin_map_a: assert property (mux_onehot_q[11:0] != 12'h0 |->
    mux_onehot_q[11:0] == 12'h1 << mux_select_q) else $error("pin channel mismatch");
  int_map_a: assert property (mux_onehot_q[13:12] != 2'h0 |->
    mux_onehot_q[13:12] == {mux_select_q == `ACS_CHS_FVR, mux_select_q == `ACS_CHS_TEMP})
    else $error("internal channel mismatch");
  ref_sel_a: assert property (wr_ok && paddr == `ACS_OFF_CTRL1 && !pwdata[0]
    |-> ##2 pos_ref_ext_q == $past(pwdata[1], 2)) else $error("reference select wrong");
  flag_sticky_a: assert property (conv_done_flag_q &&
    !(wr_ok && paddr == `ACS_OFF_FLAG && pwdata[0]) |=> conv_done_flag_q)
    else $error("done flag lost");
  sleep_abort_a: assert property ((sleep_in && cs_q[1:0] != 2'h3) [*5]
    |-> !analog_power_q) else $error("powered in sleep with divider clock");
  wake_req_a: assert property ($rose(conv_done_flag_q) && ie_q && sleep_in
    && $past(sleep_in, 4) |-> ##[0:2] wakeup_q) else $error("no wake request");
  power_off_a: assert property ($rose(conv_done_flag_q) && !ie_q && sleep_in
    && $past(sleep_in, 4) && cs_q[1:0] == 2'h3 |-> ##[0:3] !analog_power_q)
    else $error("no power down after sleep conversion");
endmodule // acs_seq_chk

bind acs_sequencer acs_seq_chk chk (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sleep_in(sleep_in), .mux_select_q(mux_select_q),
  .mux_onehot_q(mux_onehot_q), .pos_ref_ext_q(pos_ref_ext_q),
  .analog_power_q(analog_power_q), .conv_done_flag_q(conv_done_flag_q),
  .wakeup_q(wakeup_q));

// ### verification/tb_acs_sequencer.sv
/*
 * Self-checking bench of the converter sequencer, driven over APB.
 * Assumes acs_regs.vh on the include path and the analog model beside it.
 */
`include "acs_regs.vh"
module tb_acs_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_in = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, cmp_in, rc_clk, flag, wake, pwr, pref, smp;
  logic [4:0] trg = 0, msel;
  logic [13:0] onehot;
  logic [9:0] vin = 0, dac, v;
  int err_count = 0, n_tests = 0, n, n0;
  logic [4:0] channel_select [8] = '{5'h00, 5'h05, 5'h0B, 5'h0C, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
  logic [2:0] cs_list [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  logic [3:0] tcode [6] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9};
  acs_sequencer uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_in(cmp_in), .rc_clock_in(rc_clk), .sleep_in(sleep_in),
    .timer0_wrap_event(trg[0]), .timer1_wrap_event(trg[1]), .timer2_period_event(trg[2]),
    .logic_cell1_output(trg[3]), .logic_cell2_output(trg[4]), .mux_select_q(msel),
    .mux_onehot_q(onehot), .pos_ref_ext_q(pref), .dac_code_q(dac), .sample_q(smp),
    .analog_power_q(pwr), .conv_done_flag_q(flag), .wakeup_q(wake));
  acs_analog_model pm (.dac_code_q(dac), .vin(vin), .cmp_in(cmp_in), .rc_clock_in(rc_clk));
  always #12.5 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Holds the request until pready is sampled high; an idle edge follows.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic conv(input logic [2:0] cs, input logic fmt, input logic [9:0] val,
    input logic [4:0] ch);
    vin <= val;
    apb(1'b1, `ACS_OFF_FLAG, 32'h1);
    apb(1'b1, `ACS_OFF_CTRL1, {24'h0, fmt, cs, 4'h0});
    // Channel settles before go; 200 us for temperature.
    apb(1'b1, `ACS_OFF_CTRL0, {25'h0, ch, 2'h1});
    repeat (ch == `ACS_CHS_TEMP ? 8000 : 20) @(posedge clk);
    apb(1'b1, `ACS_OFF_CTRL0, {25'h0, ch, 2'h3});
    n = 0;
    while (flag !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(flag), 32'h1);
  endtask
  task automatic res_chk(input logic fmt, input logic [9:0] val);
    rchk(`ACS_OFF_RESH, fmt ? {30'h0, val[9:8]} : {24'h0, val[9:2]});
    rchk(`ACS_OFF_RESL, fmt ? {24'h0, val[7:0]} : {24'h0, val[1:0], 6'h0});
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rchk(`ACS_OFF_CTRL0, 32'h0);
    rchk(`ACS_OFF_CTRL1, 32'h0);
    rchk(`ACS_OFF_FLAG, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk(32'(er), 32'h1);
    foreach (channel_select[i]) begin
      apb(1'b1, `ACS_OFF_CTRL0, {25'h0, channel_select[i], 2'h1});
      apb(1'b1, `ACS_OFF_CTRL1, {30'h0, i[0], 1'b0});
      repeat (2) @(posedge clk);
      chk(32'(msel), 32'(channel_select[i]));
      chk(32'(pref), 32'(i[0]));
      chk(32'(onehot), channel_select[i] <= 5'h0B ? 32'h1 << channel_select[i] : channel_select[i] == 5'h1D ? 32'h1000 :
        channel_select[i] == 5'h1F ? 32'h2000 : 32'h0);
    end
    foreach (cs_list[i]) begin
      v = 10'h2A5 ^ 10'(i * 83);
      conv(cs_list[i], i[0], v, 5'h00);
      if (i == 0) n0 = n;
      chk(32'(n - n0), 32'(23 * ((1 << i) - 1)));
      rchk(`ACS_OFF_CTRL0, 32'h1);
      rchk(`ACS_OFF_FLAG, 32'h1);
      if (i > 0) res_chk(i[0], v);
    end
    conv(3'h1, 1'b0, 10'h1A3, `ACS_CHS_TEMP);
    res_chk(1'b0, 10'h1A3);
    conv(3'h7, 1'b1, 10'h155, 5'h00);
    chk(32'(flag), 32'h1);
    res_chk(1'b1, 10'h155);
    apb(1'b1, `ACS_OFF_INTEN, 32'h1);
    sleep_in <= 1'b1;
    // Sleep conversions use the RC clock.
    conv(3'h3, 1'b1, 10'h0F0, 5'h00);
    repeat (3) @(posedge clk);
    chk(32'(wake), 32'h1);
    apb(1'b1, `ACS_OFF_INTEN, 32'h0);
    conv(3'h3, 1'b1, 10'h0F0, 5'h00);
    repeat (4) @(posedge clk);
    chk(32'(pwr), 32'h0);
    chk(32'(smp), 32'h0);
    rchk(`ACS_OFF_CTRL0, 32'h1);
    sleep_in <= 1'b0;
    apb(1'b1, `ACS_OFF_FLAG, 32'h1);
    apb(1'b1, `ACS_OFF_CTRL1, 32'hE0);
    apb(1'b1, `ACS_OFF_CTRL0, 32'h3);
    repeat (50) @(posedge clk);
    sleep_in <= 1'b1;
    repeat (800) @(posedge clk);
    chk(32'(flag), 32'h0);
    apb(1'b0, `ACS_OFF_CTRL0, 32'h0);
    chk(32'(rd[0]), 32'h1);
    sleep_in <= 1'b0;
    vin <= 10'h200;
    // The synchronised Sleep level must drop before go, or the start is refused.
    repeat (4) @(posedge clk);
    apb(1'b1, `ACS_OFF_CTRL0, 32'h3);
    repeat (400) @(posedge clk);
    apb(1'b1, `ACS_OFF_CTRL0, 32'h1);
    repeat (4) @(posedge clk);
    res_chk(1'b1, 10'h200);
    apb(1'b1, `ACS_OFF_CTRL0, 32'h0);
    apb(1'b1, `ACS_OFF_FLAG, 32'h1);
    apb(1'b1, `ACS_OFF_CTRL1, 32'h0);
    apb(1'b1, `ACS_OFF_CTRL0, 32'h3);
    repeat (60) @(posedge clk);
    chk(32'(flag), 32'h0);
    apb(1'b1, `ACS_OFF_CTRL0, 32'h1);
    foreach (tcode[j]) begin
      apb(1'b1, `ACS_OFF_FLAG, 32'h1);
      apb(1'b1, `ACS_OFF_CTRL2, {24'h0, tcode[j], 4'h0});
      trg <= j ? ~(5'h1 << (j - 1)) : 5'h1F;
      repeat (60) @(posedge clk);
      chk(32'(flag), 32'h0);
      trg <= 5'h1F;
      // Trigger edges are spaced beyond a whole conversion.
      repeat (60) @(posedge clk);
      chk(32'(flag), 32'(j != 0));
      trg <= 5'h0;
      repeat (8) @(posedge clk);
    end
    apb(1'b1, `ACS_OFF_CTRL1, 32'h60);
    apb(1'b1, `ACS_OFF_CTRL0, 32'h3);
    repeat (100) @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rchk(`ACS_OFF_CTRL0, 32'h0);
    rchk(`ACS_OFF_CTRL1, 32'h0);
    repeat (800) @(posedge clk);
    chk(32'(flag | pwr), 32'h0);
    close_out();
  end
endmodule // tb_acs_sequencer
